// file: include/lrf_pkg.sv
/*
  Shared constants and types of the LIN relay fault and status block.
  Assumes a 25 MHz system clock; all counts below derive from it.
*/
package lrf_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int NCH = 8;
  // Channels 3 and 7 (zero based) carry local sensors and field reporting
  localparam int CH_HI_A = 3;
  localparam int CH_HI_B = 7;
  // Bit rate window and tolerance
  localparam int BR_MIN_BPS = 1000;
  localparam int BR_MAX_BPS = 20000;
  localparam int BR_TOL_PCT = 2;
  localparam int BIT_CYC_MAX = CLK_HZ / BR_MIN_BPS;
  localparam int BIT_CYC_MIN = CLK_HZ / BR_MAX_BPS;
  localparam int BIT_ACC_MIN = BIT_CYC_MIN * (100 - BR_TOL_PCT) / 100;
  localparam int BIT_ACC_MAX = BIT_CYC_MAX * (100 + BR_TOL_PCT) / 100;
  localparam int BRK_MIN_BITS = 11;
  localparam int SYNC_CNT_MAX = 9 * BIT_CYC_MAX;
  localparam logic [3:0] FRAME_LAST_IDX = 4'h9;
  localparam logic [7:0] CSUM_OK = 8'hff;
  localparam logic [5:0] ID_DIAG_REQ = 6'h3c;
  localparam logic [5:0] ID_DIAG_RSP = 6'h3d;
  // Times in their own units, then cycle counts
  localparam int WAKE_US = 30;
  localparam int WAKE_CYC = (WAKE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int OC_FILT_US = 10;
  localparam int OC_FILT_CYC = OC_FILT_US * CLK_HZ / 1_000_000;
  localparam int BUS_IDLE_TIMEOUT_MS = 4;
  localparam int IDLE_TIMEOUT_CYC = BUS_IDLE_TIMEOUT_MS * (CLK_HZ / 1000);
  // Strap decoding
  localparam logic [7:0] NAD_BASE = 8'h60;
  localparam logic [2:0] NAD_CODE_MAX = 3'h6;
  localparam int POSITION_STRAP_PIN_PRIME_BIT = 2;
  // Channel command encoding
  localparam logic [1:0] CMD_OFF = 2'h1;
  localparam logic [1:0] CMD_ON = 2'h2;
  // Error codes, higher value reported first
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam int ERR_RESET = 1;
  localparam int ERR_DATA = 4;
  localparam int ERR_CSUM = 5;
  localparam int ERR_FRAME = 6;
  localparam int ERR_PARITY = 7;
  // Application field bits
  localparam int APP_GTSD_BIT = 2;
  localparam int APP_LOCAL_BIT = 3;

  typedef enum logic [2:0] {MD_OFF, MD_INIT, MD_NORMAL, MD_UV, MD_SLEEP} lrf_mode_t;
  typedef enum logic [2:0] {RX_IDLE, RX_BRK, RX_DEL, RX_SYNC, RX_WAIT, RX_BIT} lrf_rx_t;
endpackage

// file: rtl/lrf_sync.sv
/*
  Two flip-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; multi-bit codes must be stable when read.
*/
`timescale 1ns/1ps
module lrf_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lrf_sync_st_t;

  lrf_sync_st_t s_r;
  lrf_sync_st_t s_nxt;

  always_comb
  begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign q = s_r.s2;
endmodule

// file: rtl/lrf_chan.sv
/*
  One low-side channel: commanded state, overcurrent filter, fault latch.
  Assumes synchronised fault levels and one-cycle command pulses.
*/
`timescale 1ns/1ps
module lrf_chan #(
  parameter int unsigned FILT_CYC = lrf_pkg::OC_FILT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fault levels
  input wire logic oc,
  input wire logic lot,
  // Control
  input wire logic cmd_on,
  input wire logic cmd_off,
  input wire logic hold,
  input wire logic clear,
  // State
  output logic drv,
  output logic fault
);
  localparam int FW = $clog2(FILT_CYC + 2);

  typedef struct packed {
    logic want;
    logic fault;
    logic drv;
    logic [FW-1:0] cnt;
  } lrf_chan_st_t;

  lrf_chan_st_t s_r;
  lrf_chan_st_t s_nxt;
  logic trip;

  always_comb
  begin
    s_nxt = s_r;
    trip = 1'b0;
    if (!oc)
      s_nxt.cnt = '0;
    else if (s_r.cnt != FW'(FILT_CYC + 1))
      s_nxt.cnt = s_r.cnt + 1'b1;
    // Overcurrent trips only after standing past the filter time; lot trips at once
    trip = (oc && s_r.cnt >= FW'(FILT_CYC)) || lot;
    if (clear)
    begin
      s_nxt.want = 1'b0;
      s_nxt.fault = 1'b0;
    end
    else
    begin
      if (cmd_off)
      begin
        s_nxt.want = 1'b0;
        s_nxt.fault = 1'b0;
      end
      if (cmd_on && !s_r.fault)
        s_nxt.want = 1'b1;
      // A trip in the same cycle as an off command still latches
      if (trip && s_r.want)
        s_nxt.fault = 1'b1;
    end
    s_nxt.drv = s_nxt.want && !s_nxt.fault && !hold;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign drv = s_r.drv;
  assign fault = s_r.fault;
endmodule

// file: rtl/lrf_top.sv
/*
  Fault protection, mode control, LIN frame checking and status reporting
  of an eight channel LIN relay driver.
  Assumes analogue comparators deliver level flags, a frame decoder elsewhere
  issues channel commands and request strobes on the same clock, and the
  transmit path reports the bit it drives on TX_BIT while TX_ACTIVE is high.
*/
`timescale 1ns/1ps
module lrf_top #(
  parameter int unsigned IDLE_TIMEOUT_CYC = lrf_pkg::IDLE_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Bus pin and own transmit path
  input wire logic LIN_RX,
  input wire logic TX_ACTIVE,
  input wire logic TX_BIT,
  // Analogue fault and supply flags
  input wire logic [7:0] OVERCURRENT,
  input wire logic [1:0] LOCAL_OVERTEMP,
  input wire logic GLOBAL_OVERTEMP,
  input wire logic SUPPLY_UNDERVOLTAGE_LOW,
  input wire logic SUPPLY_UNDERVOLTAGE_HIGH,
  input wire logic SUPPLY_POR_LOW,
  // Strap comparators
  input wire logic STRAP_VALID,
  input wire logic [2:0] NAD_CODE,
  input wire logic [2:0] POSITION_STRAP_PIN,
  // Decoded frame requests
  input wire logic CMD_STB,
  input wire logic [15:0] CMD_CODES,
  input wire logic STATUS_REQ,
  input wire logic RESET_FRAME,
  input wire logic SLEEP_CMD,
  // Drivers and status
  output logic [7:0] DRV_ON,
  output logic [7:0] OUT_STATUS,
  output logic [4:0] APPINFO,
  output logic [7:0] STATUS_BYTE,
  // Mode
  output logic LIN_ON,
  output logic SLEEPING,
  output logic UNDERVOLTAGE,
  output logic THERMAL_SHUTDOWN,
  // Node identity
  output logic [7:0] NODE_NAD,
  output logic [1:0] NODE_POS,
  output logic NODE_PRIME,
  // Received bytes
  output logic [7:0] RX_DATA,
  output logic [3:0] RX_INDEX,
  output logic RX_STROBE,
  output logic [15:0] BIT_CYCLES
);
  localparam int IW = $clog2(IDLE_TIMEOUT_CYC + 1);
  localparam logic [19:0] CNT_MAX = 20'hfffff;

  typedef struct packed {
    lrf_pkg::lrf_mode_t mode;
    lrf_pkg::lrf_rx_t rxs;
    logic lin_q;
    logic [19:0] cnt;
    logic [19:0] brk;
    logic [1:0] edges;
    logic [15:0] bitc;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [3:0] idx;
    logic [7:0] sum;
    logic [IW-1:0] idle;
    logic [15:0] wake;
    logic [7:1] errf;
    logic [7:0] stat;
    logic [4:0] app;
    logic [7:0] nad;
    logic [1:0] pos;
    logic prime;
    logic [7:0] rxd;
    logic [3:0] rxi;
    logic rx_stb;
    logic tsd;
    logic clr;
  } lrf_top_st_t;

  lrf_top_st_t s_r;
  lrf_top_st_t s_nxt;

  logic [21:0] syn;
  logic lin;
  logic [7:0] oc;
  logic [1:0] lot;
  logic gtsd;
  logic uvl;
  logic uvh;
  logic porl;
  logic strap_ok;
  logic [2:0] nadc;
  logic [2:0] confc;
  logic [7:0] drv_v;
  logic [7:0] flt_v;

  // Decode one channel command into {on, off}
  function automatic logic [1:0] cmd_dec(input logic [1:0] c);
    return {c == lrf_pkg::CMD_ON, c == lrf_pkg::CMD_OFF};
  endfunction

  function automatic logic pid_ok(input logic [7:0] p);
    logic p0;
    logic p1;
    p0 = p[0] ^ p[1] ^ p[2] ^ p[4];
    p1 = ~(p[1] ^ p[3] ^ p[4] ^ p[5]);
    return (p[6] == p0) && (p[7] == p1);
  endfunction

  function automatic logic [7:0] add_wrap(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[7:0] + {7'h0, t[8]};
  endfunction

  function automatic logic [2:0] err_top(input logic [7:1] f);
    logic [2:0] c;
    c = lrf_pkg::ERR_NONE;
    for (int i = 1; i <= 7; i++)
      if (f[i])
        c = 3'(i);
    return c;
  endfunction

  lrf_sync #(
    .W(22)
  ) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d({LIN_RX, OVERCURRENT, LOCAL_OVERTEMP, GLOBAL_OVERTEMP,
        SUPPLY_UNDERVOLTAGE_LOW, SUPPLY_UNDERVOLTAGE_HIGH, SUPPLY_POR_LOW,
        STRAP_VALID, NAD_CODE, POSITION_STRAP_PIN}),
    .q(syn)
  );

  assign {lin, oc, lot, gtsd, uvl, uvh, porl, strap_ok, nadc, confc} = syn;

  genvar gi;
  generate
    for (gi = 0; gi < lrf_pkg::NCH; gi++)
    begin : g_ch
      logic [1:0] dec;
      logic lot_i;
      assign dec = cmd_dec(CMD_CODES[2*gi+1:2*gi]);
      // Only channels 4 and 8 have a local temperature sensor
      assign lot_i = (gi == lrf_pkg::CH_HI_A) ? lot[0] :
                     (gi == lrf_pkg::CH_HI_B) ? lot[1] : 1'b0;
      lrf_chan u_chan (
        .clk(CLK_SYS),
        .rst(RST),
        .oc(oc[gi]),
        .lot(lot_i),
        .cmd_on(CMD_STB && dec[1]),
        .cmd_off(CMD_STB && dec[0]),
        .hold(s_r.tsd),
        .clear(s_r.clr),
        .drv(drv_v[gi]),
        .fault(flt_v[gi])
      );
    end
  endgenerate

  always_comb
  begin
    logic fall;
    logic rise;
    logic expired;
    logic ok;
    logic [15:0] cand;
    logic [19:0] tgt;
    logic [7:1] set_v;
    logic [7:1] clr_v;
    logic [2:0] code;
    fall = 1'b0;
    rise = 1'b0;
    expired = 1'b0;
    ok = 1'b0;
    cand = '0;
    tgt = '0;
    set_v = '0;
    clr_v = '0;
    code = lrf_pkg::ERR_NONE;
    s_nxt = s_r;
    s_nxt.lin_q = lin;
    s_nxt.rx_stb = 1'b0;
    s_nxt.clr = 1'b0;
    s_nxt.tsd = gtsd;
    fall = s_r.lin_q && !lin;
    rise = !s_r.lin_q && lin;
    expired = s_r.idle >= IW'(IDLE_TIMEOUT_CYC - 1);

    // Idle timer: reset by a falling edge only while the receiver listens
    if (s_r.mode == lrf_pkg::MD_NORMAL || s_r.mode == lrf_pkg::MD_UV)
    begin
      if (s_r.mode == lrf_pkg::MD_NORMAL && fall)
        s_nxt.idle = '0;
      else if (!expired)
        s_nxt.idle = s_r.idle + 1'b1;
    end
    else
      s_nxt.idle = '0;

    case (s_r.mode)
      lrf_pkg::MD_OFF:
      begin
        if (!porl)
        begin
          s_nxt.mode = lrf_pkg::MD_INIT;
          set_v[lrf_pkg::ERR_RESET] = 1'b1;
        end
      end
      lrf_pkg::MD_INIT:
      begin
        if (strap_ok)
        begin
          if (nadc <= lrf_pkg::NAD_CODE_MAX)
          begin
            s_nxt.nad = lrf_pkg::NAD_BASE + {4'h0, nadc, 1'b0};
            s_nxt.pos = confc[1:0];
            s_nxt.prime = confc[lrf_pkg::POSITION_STRAP_PIN_PRIME_BIT];
            s_nxt.mode = lrf_pkg::MD_NORMAL;
          end
          else
            s_nxt.mode = lrf_pkg::MD_SLEEP;
        end
      end
      lrf_pkg::MD_NORMAL:
      begin
        if (uvl)
          s_nxt.mode = lrf_pkg::MD_UV;
        else if (SLEEP_CMD || expired)
          s_nxt.mode = lrf_pkg::MD_SLEEP;
      end
      lrf_pkg::MD_UV:
      begin
        if (uvh)
          s_nxt.mode = lrf_pkg::MD_NORMAL;
        else if (expired)
          s_nxt.mode = lrf_pkg::MD_SLEEP;
      end
      lrf_pkg::MD_SLEEP:
      begin
        if (!lin)
        begin
          if (s_r.wake != 16'hffff)
            s_nxt.wake = s_r.wake + 1'b1;
        end
        else
        begin
          if (s_r.wake >= 16'(lrf_pkg::WAKE_CYC))
            s_nxt.mode = lrf_pkg::MD_INIT;
          s_nxt.wake = '0;
        end
      end
      default:
        s_nxt.mode = lrf_pkg::MD_INIT;
    endcase
    if (porl)
      s_nxt.mode = lrf_pkg::MD_OFF;

    if (RESET_FRAME && s_r.mode == lrf_pkg::MD_NORMAL)
    begin
      set_v[lrf_pkg::ERR_RESET] = 1'b1;
      s_nxt.clr = 1'b1;
    end
    // Drivers drop their commands outside normal and undervoltage modes
    if (s_nxt.mode != lrf_pkg::MD_NORMAL && s_nxt.mode != lrf_pkg::MD_UV)
      s_nxt.clr = 1'b1;

    // Receiver with bit rate learnt from the sync field
    tgt = (s_r.bitn == 4'h0) ? {5'h0, s_r.bitc[15:1]} : {4'h0, s_r.bitc};
    case (s_r.rxs)
      lrf_pkg::RX_IDLE:
      begin
        s_nxt.cnt = '0;
        if (fall)
          s_nxt.rxs = lrf_pkg::RX_BRK;
      end
      lrf_pkg::RX_BRK:
      begin
        if (s_r.cnt != CNT_MAX)
          s_nxt.cnt = s_r.cnt + 1'b1;
        if (rise)
        begin
          s_nxt.brk = s_r.cnt;
          s_nxt.cnt = '0;
          s_nxt.rxs = lrf_pkg::RX_DEL;
        end
      end
      lrf_pkg::RX_DEL:
      begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (fall)
        begin
          s_nxt.cnt = '0;
          s_nxt.edges = '0;
          s_nxt.rxs = lrf_pkg::RX_SYNC;
        end
        else if (s_r.cnt >= s_r.brk)
          s_nxt.rxs = lrf_pkg::RX_IDLE;
      end
      lrf_pkg::RX_SYNC:
      begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (fall)
        begin
          s_nxt.edges = s_r.edges + 1'b1;
          // Start bit to fall of bit 7 spans eight bit times
          if (s_r.edges == 2'h3)
          begin
            cand = s_r.cnt[18:3];
            ok = cand >= 16'(lrf_pkg::BIT_ACC_MIN) && cand <= 16'(lrf_pkg::BIT_ACC_MAX)
                 && s_r.brk >= {4'h0, cand} * 20'(lrf_pkg::BRK_MIN_BITS);
            s_nxt.cnt = '0;
            s_nxt.idx = '0;
            s_nxt.rxs = ok ? lrf_pkg::RX_WAIT : lrf_pkg::RX_IDLE;
            if (ok)
              s_nxt.bitc = cand;
          end
        end
        else if (s_r.cnt >= 20'(lrf_pkg::SYNC_CNT_MAX))
          s_nxt.rxs = lrf_pkg::RX_IDLE;
      end
      lrf_pkg::RX_WAIT:
      begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (fall)
        begin
          s_nxt.cnt = '0;
          s_nxt.bitn = '0;
          s_nxt.rxs = lrf_pkg::RX_BIT;
        end
        else if (s_r.cnt >= {s_r.bitc, 4'h0})
          s_nxt.rxs = lrf_pkg::RX_IDLE;
      end
      lrf_pkg::RX_BIT:
      begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == tgt)
        begin
          s_nxt.cnt = '0;
          s_nxt.bitn = s_r.bitn + 1'b1;
          if (TX_ACTIVE && s_r.bitn != 4'h0 && lin != TX_BIT)
            set_v[lrf_pkg::ERR_DATA] = 1'b1;
          if (s_r.bitn == 4'h0)
          begin
            if (lin)
              s_nxt.rxs = lrf_pkg::RX_IDLE;
          end
          else if (s_r.bitn <= 4'h8)
            s_nxt.sh = {lin, s_r.sh[7:1]};
          else if (!lin)
          begin
            set_v[lrf_pkg::ERR_FRAME] = 1'b1;
            s_nxt.rxs = lrf_pkg::RX_IDLE;
          end
          else
          begin
            s_nxt.rxs = lrf_pkg::RX_WAIT;
            s_nxt.rxd = s_r.sh;
            s_nxt.rxi = s_r.idx;
            s_nxt.rx_stb = 1'b1;
            s_nxt.idx = s_r.idx + 1'b1;
            if (s_r.idx == 4'h0)
            begin
              // Diagnostic frames use the classic sum without the identifier
              s_nxt.sum = (s_r.sh[5:0] == lrf_pkg::ID_DIAG_REQ ||
                           s_r.sh[5:0] == lrf_pkg::ID_DIAG_RSP) ? 8'h00 : s_r.sh;
              if (!pid_ok(s_r.sh))
              begin
                set_v[lrf_pkg::ERR_PARITY] = 1'b1;
                s_nxt.rxs = lrf_pkg::RX_IDLE;
              end
            end
            else
            begin
              s_nxt.sum = add_wrap(s_r.sum, s_r.sh);
              if (s_r.idx == lrf_pkg::FRAME_LAST_IDX)
              begin
                if (s_nxt.sum != lrf_pkg::CSUM_OK)
                  set_v[lrf_pkg::ERR_CSUM] = 1'b1;
                s_nxt.rxs = lrf_pkg::RX_IDLE;
              end
            end
          end
        end
      end
      default:
        s_nxt.rxs = lrf_pkg::RX_IDLE;
    endcase
    // Transceiver off outside normal mode
    if (s_r.mode != lrf_pkg::MD_NORMAL)
      s_nxt.rxs = lrf_pkg::RX_IDLE;

    s_nxt.app = '0;
    s_nxt.app[lrf_pkg::APP_GTSD_BIT] = s_r.tsd;
    s_nxt.app[lrf_pkg::APP_LOCAL_BIT] = !s_r.tsd &&
      (flt_v[lrf_pkg::CH_HI_A] || flt_v[lrf_pkg::CH_HI_B]);

    code = err_top(s_r.errf);
    if (STATUS_REQ)
    begin
      s_nxt.stat = {s_r.app, code};
      if (code != lrf_pkg::ERR_NONE)
        clr_v[code] = 1'b1;
    end
    // A new error in the clearing cycle survives
    s_nxt.errf = (s_r.errf & ~clr_v) | set_v;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      s_r <= '0;
      s_r.mode <= lrf_pkg::MD_INIT;
      s_r.rxs <= lrf_pkg::RX_IDLE;
      s_r.lin_q <= 1'b1;
      s_r.bitc <= 16'(lrf_pkg::BIT_CYC_MIN);
      s_r.errf <= 7'h01;
      s_r.clr <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign DRV_ON = drv_v;
  assign OUT_STATUS = flt_v;
  assign APPINFO = s_r.app;
  assign STATUS_BYTE = s_r.stat;
  assign LIN_ON = s_r.mode == lrf_pkg::MD_NORMAL;
  assign SLEEPING = s_r.mode == lrf_pkg::MD_SLEEP;
  assign UNDERVOLTAGE = s_r.mode == lrf_pkg::MD_UV;
  assign THERMAL_SHUTDOWN = s_r.tsd;
  assign NODE_NAD = s_r.nad;
  assign NODE_POS = s_r.pos;
  assign NODE_PRIME = s_r.prime;
  assign RX_DATA = s_r.rxd;
  assign RX_INDEX = s_r.rxi;
  assign RX_STROBE = s_r.rx_stb;
  assign BIT_CYCLES = s_r.bitc;
endmodule

// file: test/lrf_lin_master.sv
/*
  Behavioural LIN master: break, sync field and one identifier byte.
  Assumes the bus idles recessive through the slave pull-up, one driver only.
*/
`timescale 1ns/1ps
module lrf_lin_master #(
  parameter int BIT_CYC = 1300
) (
  // Clock
  input wire logic clk,
  // Bus level
  output logic lin
);
  initial lin = 1'h1;

  task automatic hold_bits(input logic lvl, input int n);
    lin = lvl;
    repeat (n * BIT_CYC) @(negedge clk);
  endtask

  // Start bit, eight bits least significant first, stop bit
  task automatic send_byte(input logic [7:0] b);
    hold_bits(1'h0, 1);
    for (int i = 0; i < 8; i++)
    begin
      hold_bits(b[i], 1);
    end
    hold_bits(1'h1, 1);
  endtask

  // A 13 bit break outlasts the 11 bit minimum at any learnt rate
  task automatic send_header(input logic [7:0] pid);
    hold_bits(1'h0, 13);
    hold_bits(1'h1, 1);
    send_byte(8'h55);
    send_byte(pid);
  endtask
endmodule

// file: test/lrf_top_asserts.sv
/*
  Port-level assertions of the relay fault and status block.
  Assumes it is bound into lrf_top and sees only its ports.
*/
`timescale 1ns/1ps
module lrf_chk #(
  parameter int unsigned IDLE_TIMEOUT_CYC = 2000
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Requests
  input wire logic CMD_STB,
  input wire logic STATUS_REQ,
  input wire logic RESET_FRAME,
  // Watched outputs
  input wire logic [7:0] DRV_ON,
  input wire logic [7:0] OUT_STATUS,
  input wire logic [4:0] APPINFO,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic LIN_ON,
  input wire logic UNDERVOLTAGE,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic [7:0] NODE_NAD,
  input wire logic [15:0] BIT_CYCLES
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  property p_field_excl;
    !(APPINFO[2] && APPINFO[3]);
  endproperty
  a_field_excl: assert property (p_field_excl)
    else $error("field bits 2 and 3 high together");

  property p_tsd_field;
    THERMAL_SHUTDOWN ##1 THERMAL_SHUTDOWN |-> APPINFO == 5'h04;
  endproperty
  a_tsd_field: assert property (p_tsd_field)
    else $error("field not 00100b in shutdown");

  property p_tsd_off;
    THERMAL_SHUTDOWN ##1 THERMAL_SHUTDOWN |-> DRV_ON == 8'h00;
  endproperty
  a_tsd_off: assert property (p_tsd_off)
    else $error("driver on in shutdown");

  property p_local_or;
    !THERMAL_SHUTDOWN && !$past(THERMAL_SHUTDOWN) && $stable(OUT_STATUS)
      |-> APPINFO[3] == (OUT_STATUS[3] | OUT_STATUS[7]);
  endproperty
  a_local_or: assert property (p_local_or)
    else $error("field bit 3 not OR of channel 4 and 8 faults");

  property p_fault_off;
    (OUT_STATUS & DRV_ON) == 8'h00;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("faulted channel driven on");

  property p_fault_clear;
    |($past(OUT_STATUS) & ~OUT_STATUS) |-> $past(CMD_STB) || $past(CMD_STB, 2)
      || $past(RESET_FRAME) || $past(RESET_FRAME, 2) || !(LIN_ON || UNDERVOLTAGE);
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault cleared without command");

  property p_uv_lin;
    UNDERVOLTAGE |-> !LIN_ON;
  endproperty
  a_uv_lin: assert property (p_uv_lin)
    else $error("bus active in undervoltage");

  property p_uv_keep;
    $rose(UNDERVOLTAGE) && $stable(OUT_STATUS) && !THERMAL_SHUTDOWN |-> $stable(DRV_ON);
  endproperty
  a_uv_keep: assert property (p_uv_keep)
    else $error("drivers changed on undervoltage entry");

  property p_status_app;
    STATUS_REQ |=> STATUS_BYTE[7:3] == $past(APPINFO);
  endproperty
  a_status_app: assert property (p_status_app)
    else $error("status byte field wrong");

  property p_status_hold;
    !STATUS_REQ && !RESET_FRAME && LIN_ON ##1 LIN_ON |-> $stable(STATUS_BYTE);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status byte changed without request");

  property p_nad;
    LIN_ON |-> NODE_NAD inside {[8'h60:8'h6c]} && !NODE_NAD[0];
  endproperty
  a_nad: assert property (p_nad)
    else $error("node address out of range");

  property p_bit_range;
    LIN_ON |-> BIT_CYCLES inside {[16'h04c9:16'h639c]};
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("learnt bit time out of range");
endmodule

bind lrf_top lrf_chk #(.IDLE_TIMEOUT_CYC(IDLE_TIMEOUT_CYC)) u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .CMD_STB(CMD_STB), .STATUS_REQ(STATUS_REQ),
  .RESET_FRAME(RESET_FRAME), .DRV_ON(DRV_ON), .OUT_STATUS(OUT_STATUS),
  .APPINFO(APPINFO), .STATUS_BYTE(STATUS_BYTE), .LIN_ON(LIN_ON),
  .UNDERVOLTAGE(UNDERVOLTAGE), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN),
  .NODE_NAD(NODE_NAD), .BIT_CYCLES(BIT_CYCLES)
);

// file: test/lrf_top_bench.sv
/*
  Self-checking bench: init, commands, faults, shutdown, one header, undervoltage.
  Assumes lrf_top, lrf_chk bound to it, and the behavioural master.
*/
`timescale 1ns/1ps
module lin_relay_fault_status_bench;
  // Short idle timeout, yet longer than the longest gap between bus falls
  localparam int IDLE_CYC = 20000;
  localparam int BT = 1300;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic lin_rx, lin_on, sleeping, uv, tsd, node_prime, rx_stb;
  logic [7:0] oc = 8'h00;
  logic [1:0] lot = 2'h0;
  logic got = 1'h0;
  logic uv_lo = 1'h0;
  logic uv_hi = 1'h1;
  logic [2:0] nad_code = 3'h0;
  logic [2:0] pos_pin = 3'h0;
  logic cmd_stb = 1'h0;
  logic [15:0] code = 16'h0000;
  logic status_req = 1'h0;
  logic rst_frame = 1'h0;
  logic tx_act = 1'h0;
  logic tx_bit = 1'h0;
  logic req_seen = 1'h0;
  logic [7:0] drv_on, out_status, status_byte, node_nad, rx_data, exp_drv;
  logic [4:0] appinfo;
  logic [1:0] node_pos;
  logic [3:0] rx_idx;
  logic [15:0] bit_cyc;
  logic [7:0] st_q[$];
  logic [11:0] rx_q[$];
  int error_cnt = 0;
  int tests_run = 0;

  always #20 clk = ~clk;

  lrf_lin_master #(.BIT_CYC(BT)) u_master (.clk(clk), .lin(lin_rx));

  lrf_top #(.IDLE_TIMEOUT_CYC(IDLE_CYC)) u_dut (
    .CLK_SYS(clk), .RST(rst), .LIN_RX(lin_rx), .TX_ACTIVE(tx_act), .TX_BIT(tx_bit),
    .OVERCURRENT(oc), .LOCAL_OVERTEMP(lot), .GLOBAL_OVERTEMP(got),
    .SUPPLY_UNDERVOLTAGE_LOW(uv_lo), .SUPPLY_UNDERVOLTAGE_HIGH(uv_hi),
    .SUPPLY_POR_LOW(1'h0), .STRAP_VALID(1'h1), .NAD_CODE(nad_code),
    .POSITION_STRAP_PIN(pos_pin), .CMD_STB(cmd_stb), .CMD_CODES(code),
    .STATUS_REQ(status_req), .RESET_FRAME(rst_frame), .SLEEP_CMD(1'h0),
    .DRV_ON(drv_on), .OUT_STATUS(out_status), .APPINFO(appinfo),
    .STATUS_BYTE(status_byte), .LIN_ON(lin_on), .SLEEPING(sleeping),
    .UNDERVOLTAGE(uv), .THERMAL_SHUTDOWN(tsd), .NODE_NAD(node_nad),
    .NODE_POS(node_pos), .NODE_PRIME(node_prime), .RX_DATA(rx_data),
    .RX_INDEX(rx_idx), .RX_STROBE(rx_stb), .BIT_CYCLES(bit_cyc)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic command(input logic [15:0] c);
    code = c;
    cmd_stb = 1'h1;
    ticks(1);
    cmd_stb = 1'h0;
    ticks(3);
  endtask

  task automatic status(input logic [7:0] exp);
    st_q.push_back(exp);
    status_req = 1'h1;
    ticks(1);
    status_req = 1'h0;
    ticks(2);
  endtask

  function automatic logic [7:0] next_drv(input logic [7:0] cur, input logic [15:0] c);
    logic [7:0] n;
    n = cur;
    for (int i = 0; i < 8; i++)
    begin
      if (c[2*i +: 2] == 2'h1)
        n[i] = 1'h0;
      else if (c[2*i +: 2] == 2'h2)
        n[i] = 1'h1;
    end
    return n;
  endfunction

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Results are taken off the queues in the order the driver noted them
  always @(posedge clk)
  begin
    req_seen <= status_req;
  end

  always @(negedge clk)
  begin
    if (req_seen === 1'h1 && st_q.size() > 0)
      check(status_byte, st_q.pop_front());
    if (rx_stb === 1'h1 && rx_q.size() > 0)
      check({rx_idx, rx_data}, rx_q.pop_front());
  end

  initial
  begin
    ticks(100000);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    void'($urandom(23));
    nad_code = 3'($urandom % 7);
    pos_pin = 3'($urandom);
    ticks(4);
    rst = 1'h0;
    for (int i = 0; i < 50 && lin_on !== 1'h1; i++)
      ticks(1);
    ticks(2);
    check(node_nad, 8'h60 + {4'h0, nad_code, 1'h0});
    check({node_prime, node_pos}, pos_pin);
    status(8'h01);
    status(8'h00);
    exp_drv = 8'h00;
    for (int r = 0; r < 8; r++)
    begin
      for (int c = 0; c < 8; c++)
        code[2*c +: 2] = (r < 4) ? 2'(r + c) : 2'($urandom);
      exp_drv = next_drv(exp_drv, code);
      command(code);
      check(drv_on, exp_drv);
    end
    command(16'haaaa);
    oc = 8'h09;
    ticks(270);
    check(out_status, 8'h09);
    check(drv_on, 8'hf6);
    check(appinfo, 5'h08);
    lot = 2'h2;
    ticks(6);
    check({out_status, drv_on}, 16'h8976);
    oc = 8'h00;
    lot = 2'h0;
    command(16'haaaa);
    check(drv_on, 8'h76);
    got = 1'h1;
    ticks(6);
    check({appinfo, lin_on, tsd, drv_on}, 15'h1300);
    status(8'h20);
    got = 1'h0;
    ticks(6);
    check({appinfo, tsd, drv_on}, 14'h1076);
    command(16'h4001);
    check({appinfo, out_status}, 13'h0808);
    command(16'h0040);
    check({appinfo, out_status}, 13'h0000);
    command(16'haaaa);
    check(drv_on, 8'hff);
    // A reset frame in normal mode drops every command and raises the reset error
    rst_frame = 1'h1;
    ticks(1);
    rst_frame = 1'h0;
    ticks(3);
    check(drv_on, 8'h00);
    command(16'haaaa);
    // Identifier 0x01 carries parity 0xc1; bit 7 is flipped here
    rx_q.push_back(12'h041);
    // Claiming recessive while the bus reads dominant gives data errors
    tx_act = 1'h1;
    tx_bit = 1'h1;
    u_master.send_header(8'h41);
    tx_act = 1'h0;
    check(bit_cyc >= 16'(BT * 98 / 100) && bit_cyc <= 16'(BT * 102 / 100), 1'h1);
    status(8'h07);
    status(8'h04);
    status(8'h01);
    uv_lo = 1'h1;
    uv_hi = 1'h0;
    ticks(6);
    check({uv, lin_on, drv_on}, 10'h2ff);
    uv_lo = 1'h0;
    uv_hi = 1'h1;
    ticks(6);
    check({uv, lin_on}, 2'h1);
    uv_lo = 1'h1;
    uv_hi = 1'h0;
    for (int i = 0; i < IDLE_CYC + 100 && sleeping !== 1'h1; i++)
      ticks(1);
    check(sleeping, 1'h1);
    complete_run();
  end
endmodule
